// File: hw/spsfl_sequencer.sv
// Purpose: Phase sequencer, drive gating and fault reporting, APB slave
// Assumes: mclk 20 MHz, reset synchronous active high acts as power-on
// Notes: APB answers with pready one cycle into the access phase
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/100ps
module spsfl_sequencer (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Motion controller pins
  input wire logic stepClock,
  input wire logic rotationDirection,
  input wire logic excitationSelectBit0,
  input wire logic excitationSelectBit1,
  input wire logic stepEdgeSelect,
  input wire logic enable,
  input wire logic systemResetN,
  // Sense comparators
  input wire logic overCurrentSense,
  input wire logic flybackSense,
  input wire logic overheatSense,
  input wire logic setpointReached,
  // Phase drives
  output logic phaseADrive,
  output logic phaseAInverseDrive,
  output logic phaseBDrive,
  output logic phaseBInverseDrive,
  output logic currentReduced,
  output logic excitationMonitorOut,
  // Fault outputs
  output logic anyFaultNOut,
  output logic anyFaultNOe,
  output logic [1:0] faultKindLevel
);
  import spsfl_pkg::*;

  spsfl_chop_if chopLink ();

  logic [SYNC_W-1:0] pinRaw;
  logic [SYNC_W-1:0] syncStage1;
  logic [SYNC_W-1:0] syncStage2;
  logic clkS, dirS, sel0S, sel1S, edgeS, enS, rstNS;
  logic rst;
  logic clkPrev;
  logic rise, fall, stepReq;
  logic edgeReg, dirReg;
  logic [1:0] selReg;
  spsfl_mode_t mode;
  logic [IDX_W-1:0] stepSize;
  logic [IDX_W-1:0] phaseIndex;
  logic [IDX_W-1:0] next_phaseIndex;
  logic [15:0] stepCount;
  logic driveAllow;
  logic anyFault;
  logic patA, patAInv, patB, patBInv;
  logic driveGate;
  logic apbAccess, apbDone;
  logic [31:0] next_prdata;
  logic next_pslverr;

  assign pinRaw = {systemResetN, overheatSense, setpointReached,
                   flybackSense, overCurrentSense, enable, stepEdgeSelect,
                   excitationSelectBit1, excitationSelectBit0,
                   rotationDirection, stepClock};

  // Two-stage synchronisers, one per pin
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : gSync
      always_ff @(posedge mclk)
      begin
        if (reset)
        begin
          syncStage1[gi] <= SYNC_RESET[gi];
          syncStage2[gi] <= SYNC_RESET[gi];
        end
        else
        begin
          syncStage1[gi] <= pinRaw[gi];
          syncStage2[gi] <= syncStage1[gi];
        end
      end
    end
  endgenerate

  assign clkS = syncStage2[0];
  assign dirS = syncStage2[1];
  assign sel0S = syncStage2[2];
  assign sel1S = syncStage2[3];
  assign edgeS = syncStage2[4];
  assign enS = syncStage2[5];
  assign rstNS = syncStage2[10];

  assign rst = reset || !rstNS;

  // Sense levels to the detector
  assign chopLink.overCurrentSense = syncStage2[6];
  assign chopLink.flybackSense = syncStage2[7];
  assign chopLink.setpointReached = syncStage2[8];
  assign chopLink.overheatSense = syncStage2[9];
  assign chopLink.driveActive = enS && driveAllow && !anyFault;

  spsfl_fault_det uFaultDet (
    .mclk(mclk),
    .rst(rst),
    .chop(chopLink.det)
  );

  assign anyFault = chopLink.openFault || chopLink.overCurrentFault
                    || chopLink.overheatFault;

  // Previous clock level tracked always, so enable return makes no edge
  always_ff @(posedge mclk)
  begin
    if (rst)
      clkPrev <= 1'b0;
    else
      clkPrev <= clkS;
  end

  assign rise = clkS && !clkPrev;
  assign fall = !clkS && clkPrev;

  // mode and direction frozen while disabled
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      edgeReg <= 1'b1;
      selReg <= 2'h0;
      dirReg <= 1'b0;
    end
    else if (enS)
    begin
      edgeReg <= edgeS;
      selReg <= {sel1S, sel0S};
      dirReg <= dirS;
    end
  end

  // rising edge only when edge select high
  // both edges when edge select low
  assign stepReq = enS && (rise || (!edgeReg && fall));

  always_comb
  begin
    mode = MODE_TWO_PHASE;
    if (edgeReg)
    begin
      case (selReg)
        2'h0: mode = MODE_TWO_PHASE;
        2'h1: mode = MODE_HALF;
        2'h2: mode = MODE_QUARTER;
        default: mode = MODE_EIGHTH;
      endcase
    end
    else
    begin
      case (selReg)
        2'h0: mode = MODE_HALF;
        2'h1: mode = MODE_QUARTER;
        2'h2: mode = MODE_EIGHTH;
        default: mode = MODE_SIXTEENTH;
      endcase
    end
  end

  // Step size in sixteenth microsteps per mode
  always_comb
  begin
    case (mode)
      MODE_TWO_PHASE: stepSize = STEP_TWO;
      MODE_HALF: stepSize = STEP_HALF;
      MODE_QUARTER: stepSize = STEP_QUARTER;
      MODE_EIGHTH: stepSize = STEP_EIGHTH;
      MODE_SIXTEENTH: stepSize = STEP_SIXTEENTH;
      default: stepSize = STEP_SIXTEENTH;
    endcase
  end

  assign next_phaseIndex = dirReg ? phaseIndex - stepSize
                                  : phaseIndex + stepSize;

  always_ff @(posedge mclk)
  begin
    if (rst)
      phaseIndex <= IDX_RESET;
    else if (stepReq)
      phaseIndex <= next_phaseIndex;
  end

  // Step counter for software, wraps freely
  always_ff @(posedge mclk)
  begin
    if (rst)
      stepCount <= STEPS_RESET;
    else if (stepReq)
      stepCount <= stepCount + 16'h0001;
  end

  // Winding polarity from the electrical angle
  assign patA = (phaseIndex < IDX_QUARTER) || (phaseIndex > IDX_THREE_Q);
  assign patAInv = (phaseIndex > IDX_QUARTER) && (phaseIndex < IDX_THREE_Q);
  assign patB = (phaseIndex != '0) && (phaseIndex < IDX_HALF);
  assign patBInv = phaseIndex > IDX_HALF;

  assign driveGate = chopLink.driveActive && chopLink.chopOn;

  // Drive outputs registered; one cycle of latency is harmless
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      phaseADrive <= 1'b0;
      phaseAInverseDrive <= 1'b0;
      phaseBDrive <= 1'b0;
      phaseBInverseDrive <= 1'b0;
    end
    else
    begin
      phaseADrive <= driveGate && patA;
      phaseAInverseDrive <= driveGate && patAInv;
      phaseBDrive <= driveGate && patB;
      phaseBInverseDrive <= driveGate && patBInv;
    end
  end

  // pseudo microstep 71 percent on two-phase positions
  always_ff @(posedge mclk)
  begin
    if (rst)
      currentReduced <= 1'b0;
    else
      currentReduced <= (mode == MODE_HALF) && !edgeReg && phaseIndex[3];
  end

  // Monitor high over the first half of each electrical turn
  always_ff @(posedge mclk)
  begin
    if (rst)
      excitationMonitorOut <= 1'b0;
    else
      excitationMonitorOut <= phaseIndex < IDX_HALF;
  end

  // Fault reporting; overheat outranks overcurrent outranks open
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      anyFaultNOut <= 1'b0;
      anyFaultNOe <= 1'b0;
      faultKindLevel <= FAULT_NONE;
    end
    else
    begin
      anyFaultNOut <= 1'b0;
      anyFaultNOe <= anyFault;
      if (chopLink.overheatFault)
        faultKindLevel <= FAULT_OVERHEAT;
      else if (chopLink.overCurrentFault)
        faultKindLevel <= FAULT_OVERCURRENT;
      else if (chopLink.openFault)
        faultKindLevel <= FAULT_OPEN;
      else
        faultKindLevel <= FAULT_NONE;
    end
  end

  // APB: one wait state so read data comes from a flop
  assign apbAccess = psel && penable && !pready;
  assign apbDone = psel && penable && pready;

  always_ff @(posedge mclk)
  begin
    if (reset)
      pready <= 1'b0;
    else
      pready <= apbAccess;
  end

  // Read mux and unmapped address check
  always_comb
  begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    case (paddr)
      ADDR_CTRL: next_prdata[CTRL_ALLOW_BIT] = driveAllow;
      ADDR_STATUS:
        next_prdata = {16'h0000, chopLink.overheatFault,
                       chopLink.overCurrentFault, chopLink.openFault,
                       enS, dirReg, edgeReg, selReg,
                       2'h0, phaseIndex};
      ADDR_STEPS: next_prdata = {16'h0000, stepCount};
      default: next_pslverr = 1'b1;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (apbAccess)
    begin
      prdata <= pwrite ? 32'h00000000 : next_prdata;
      pslverr <= next_pslverr;
    end
    else
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // Software drive permit; survives pin reset, set to allow by power-on only
  always_ff @(posedge mclk)
  begin
    if (reset)
      driveAllow <= CTRL_ALLOW_RESET;
    else if (apbDone && pwrite && paddr == ADDR_CTRL && pstrb[0])
      driveAllow <= pwdata[CTRL_ALLOW_BIT];
  end
endmodule // spsfl_sequencer

// File: hw/spsfl_pkg.sv
// Purpose: Shared constants and types of the stepper phase sequencer
// Assumes: 20 MHz mclk, APB register access with 32-bit data
// Notes: Phase index counts sixteenth microsteps, 64 per electrical turn
package spsfl_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int BLANK_NS = 1250;
  localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHOP_PERIOD_NS = 20000;
  localparam int CHOP_CYC = CHOP_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CHOP_W = 9;
  localparam logic [CHOP_W-1:0] CHOP_LAST = CHOP_W'(CHOP_CYC - 1);
  localparam logic [CHOP_W-1:0] BLANK_END = CHOP_W'(BLANK_CYC);

  // Pin synchroniser
  localparam int SYNC_W = 11;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 11'h400;

  // Phase index
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] IDX_RESET = 6'h08;
  localparam logic [IDX_W-1:0] IDX_QUARTER = 6'h10;
  localparam logic [IDX_W-1:0] IDX_HALF = 6'h20;
  localparam logic [IDX_W-1:0] IDX_THREE_Q = 6'h30;
  localparam logic [IDX_W-1:0] STEP_TWO = 6'h10;
  localparam logic [IDX_W-1:0] STEP_HALF = 6'h08;
  localparam logic [IDX_W-1:0] STEP_QUARTER = 6'h04;
  localparam logic [IDX_W-1:0] STEP_EIGHTH = 6'h02;
  localparam logic [IDX_W-1:0] STEP_SIXTEENTH = 6'h01;

  // Fault type codes on the fault level output
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_OPEN = 2'h1;
  localparam logic [1:0] FAULT_OVERCURRENT = 2'h2;
  localparam logic [1:0] FAULT_OVERHEAT = 2'h3;

  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_STEPS = 8'h08;
  localparam int CTRL_ALLOW_BIT = 0;
  localparam logic CTRL_ALLOW_RESET = 1'b1;
  localparam logic [15:0] STEPS_RESET = 16'h0000;

  // Excitation modes
  typedef enum logic [2:0] {
    MODE_TWO_PHASE,
    MODE_HALF,
    MODE_QUARTER,
    MODE_EIGHTH,
    MODE_SIXTEENTH
  } spsfl_mode_t;

  // Chopper states
  typedef enum logic {
    CHOP_ON,
    CHOP_OFF
  } spsfl_chop_t;
endpackage

// File: hw/spsfl_chop_if.sv
// Purpose: Links the sequencer core with its chopper and fault detector
// Assumes: All signals on mclk, senses already synchronised
// Notes: Fault flags are latched inside the detector
`timescale 1ns/100ps
interface spsfl_chop_if;
  logic driveActive;
  logic overCurrentSense;
  logic flybackSense;
  logic overheatSense;
  logic setpointReached;
  logic chopOn;
  logic openFault;
  logic overCurrentFault;
  logic overheatFault;

  modport core (
    output driveActive, overCurrentSense, flybackSense, overheatSense,
    output setpointReached,
    input chopOn, openFault, overCurrentFault, overheatFault
  );
  modport det (
    input driveActive, overCurrentSense, flybackSense, overheatSense,
    input setpointReached,
    output chopOn, openFault, overCurrentFault, overheatFault
  );
endinterface

// File: hw/spsfl_fault_det.sv
// Purpose: Chopping cycle timing and latched fault detection
// Assumes: rst is the combined internal reset, senses synchronised
// Notes: Faults clear only through rst
`timescale 1ns/100ps
module spsfl_fault_det (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link to the core
  spsfl_chop_if.det chop
);
  import spsfl_pkg::*;

  logic [CHOP_W-1:0] chopCount;
  spsfl_chop_t chopState;
  logic flybackSeen;
  logic offSeen;
  logic periodEnd;

  assign periodEnd = (chopCount == CHOP_LAST);

  // Chopping period counter, held at zero while drive is inactive
  always_ff @(posedge mclk)
  begin
    if (rst || !chop.driveActive || periodEnd)
      chopCount <= '0;
    else
      chopCount <= chopCount + 1'b1;
  end

  // On until setpoint reached after blanking, off to period end
  // blank setpoint during ringing
  always_ff @(posedge mclk)
  begin
    if (rst || !chop.driveActive)
      chopState <= CHOP_ON;
    else
    begin
      case (chopState)
        CHOP_ON:
          if (chop.setpointReached && chopCount >= BLANK_END && !periodEnd)
            chopState <= CHOP_OFF;
        CHOP_OFF:
          if (periodEnd)
            chopState <= CHOP_ON;
        default:
          chopState <= CHOP_ON;
      endcase
    end
  end

  assign chop.chopOn = (chopState == CHOP_ON);

  // Flyback watch over the off portion of each period
  always_ff @(posedge mclk)
  begin
    if (rst || !chop.driveActive || periodEnd)
    begin
      flybackSeen <= 1'b0;
      offSeen <= 1'b0;
    end
    else if (chopState == CHOP_OFF)
    begin
      offSeen <= 1'b1;
      if (chop.flybackSense)
        flybackSeen <= 1'b1;
    end
  end

  // Sticky fault latches; only the reset clears them
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      chop.openFault <= 1'b0;
      chop.overCurrentFault <= 1'b0;
      chop.overheatFault <= 1'b0;
    end
    else
    begin
      if (chop.driveActive && periodEnd && offSeen && !flybackSeen
          && !chop.flybackSense)
        chop.openFault <= 1'b1;
      if (chop.driveActive && chopState == CHOP_ON
          && chopCount >= BLANK_END && chop.overCurrentSense)
        chop.overCurrentFault <= 1'b1;
      if (chop.overheatSense)
        chop.overheatFault <= 1'b1;
    end
  end
endmodule // spsfl_fault_det

// File: bench/spsfl_sequencer_assertions.sv
// Purpose: Port-level checks of the phase sequencer
// Assumes: Bound to spsfl_sequencer, one mclk domain
// Notes: Pins pass a two-flop sync, so windows allow a few edges
`timescale 1ns/100ps
module spsfl_sequencer_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Pins and bus
  input wire logic stepClock,
  input wire logic stepEdgeSelect,
  input wire logic enable,
  input wire logic systemResetN,
  input wire logic psel,
  input wire logic pready,
  // Drives and flags
  input wire logic phaseADrive,
  input wire logic phaseAInverseDrive,
  input wire logic phaseBDrive,
  input wire logic phaseBInverseDrive,
  input wire logic currentReduced,
  input wire logic excitationMonitorOut,
  input wire logic anyFaultNOut,
  input wire logic anyFaultNOe,
  input wire logic [1:0] faultKindLevel
);
  import spsfl_pkg::*;
  logic drv;
  // Any phase on
  assign drv = phaseADrive | phaseAInverseDrive | phaseBDrive
    | phaseBInverseDrive;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_drive_off_disabled: assert property (
    !enable [*4] |-> !drv) else $error("drive on while disabled");
  a_fault_drive_off: assert property (
    anyFaultNOe [*2] |-> !drv) else $error("drive on with fault");
  a_fault_sticky: assert property (
    anyFaultNOe && systemResetN && $past(systemResetN)
    && $past(systemResetN, 2) && $past(systemResetN, 3) |=> anyFaultNOe)
    else $error("fault cleared without reset");
  a_fault_kind_match: assert property (
    anyFaultNOe == (faultKindLevel != FAULT_NONE))
    else $error("fault kind and flag disagree");
  a_fault_pin_low: assert property (
    anyFaultNOe |-> !anyFaultNOut) else $error("fault pin not low");
  a_monitor_frozen: assert property (
    (!enable && systemResetN) [*6] |=> $stable(excitationMonitorOut))
    else $error("index moved while disabled");
  a_idle_index_kept: assert property (
    ($stable(stepClock) && systemResetN) [*6]
    |=> $stable(excitationMonitorOut)) else $error("index moved idle");
  a_full_current_rise: assert property (
    (stepEdgeSelect && enable) [*6] |-> !currentReduced)
    else $error("reduced current in rising mode");
  a_drive_exclusive: assert property (
    !(phaseADrive && phaseAInverseDrive)
    && !(phaseBDrive && phaseBInverseDrive)) else $error("both halves on");
  // Main scenarios reached
  c_fault: cover property (anyFaultNOe);
  c_both_edge: cover property (!stepEdgeSelect && $rose(excitationMonitorOut));
  c_bus: cover property (psel && pready);
endmodule // spsfl_sequencer_assertions

bind spsfl_sequencer spsfl_sequencer_assertions chk (
  .mclk(mclk), .reset(reset), .stepClock(stepClock),
  .stepEdgeSelect(stepEdgeSelect), .enable(enable),
  .systemResetN(systemResetN), .psel(psel), .pready(pready),
  .phaseADrive(phaseADrive), .phaseAInverseDrive(phaseAInverseDrive),
  .phaseBDrive(phaseBDrive), .phaseBInverseDrive(phaseBInverseDrive),
  .currentReduced(currentReduced),
  .excitationMonitorOut(excitationMonitorOut),
  .anyFaultNOut(anyFaultNOut), .anyFaultNOe(anyFaultNOe),
  .faultKindLevel(faultKindLevel)
);

// File: bench/spsfl_motion_ctl.sv
// Purpose: Motion controller model making step clock bursts
// Assumes: Requests arrive only while the model is idle
// Notes: Clock rests low between bursts
`timescale 1ns/100ps
module spsfl_motion_ctl (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Request
  input wire logic go,
  input wire logic bothEdges,
  input wire logic [1:0] pulses,
  // Pins
  output logic stepClock,
  output logic busy
);
  // Burst engine, quiet time on both sides
  initial
  begin
    stepClock = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge mclk);
      if (go && !reset)
      begin
        busy <= 1'b1;
        repeat (200) @(posedge mclk);
        for (int i = 0; i < pulses; i++)
        begin
          stepClock <= 1'b1;
          repeat (bothEdges ? 450 : 180) @(posedge mclk);
          stepClock <= 1'b0;
          repeat (bothEdges ? 550 : 220) @(posedge mclk);
        end
        repeat (200) @(posedge mclk);
        busy <= 1'b0;
      end
    end
  end
endmodule // spsfl_motion_ctl

// File: bench/tb_spsfl_sequencer.sv
// Purpose: Self-checking bench of the phase sequencer
// Assumes: Controller model makes all step clock edges
// Notes: Read answers are matched against queued notes
`timescale 1ns/100ps
module tb_spsfl_sequencer;
  import spsfl_pkg::*;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, obs, flt;
  logic [31:0] pwdata, prdata, seed;
  logic [3:0] pstrb;
  logic stepClock, rotationDirection, bit0, bit1, stepEdgeSelect, enable;
  logic systemResetN, overCurrentSense, flybackSense, overheatSense;
  logic setpointReached, pa, pai, pb, pbi, currentReduced, monitorOut;
  logic anyFaultNOut, anyFaultNOe, go, bothEdges, busy;
  logic [1:0] faultKindLevel, pulses;
  logic [64:0] note;
  logic [64:0] notes[$];
  int fails, n_tests, cyc, idx, steps, n;
  spsfl_sequencer dut (.mclk(mclk), .reset(reset), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .stepClock(stepClock), .rotationDirection(rotationDirection),
    .excitationSelectBit0(bit0), .excitationSelectBit1(bit1),
    .stepEdgeSelect(stepEdgeSelect), .enable(enable),
    .systemResetN(systemResetN), .overCurrentSense(overCurrentSense),
    .flybackSense(flybackSense), .overheatSense(overheatSense),
    .setpointReached(setpointReached), .phaseADrive(pa),
    .phaseAInverseDrive(pai), .phaseBDrive(pb), .phaseBInverseDrive(pbi),
    .currentReduced(currentReduced), .excitationMonitorOut(monitorOut),
    .anyFaultNOut(anyFaultNOut), .anyFaultNOe(anyFaultNOe),
    .faultKindLevel(faultKindLevel));
  spsfl_motion_ctl ctl (.mclk(mclk), .reset(reset), .go(go),
    .bothEdges(bothEdges), .pulses(pulses), .stepClock(stepClock),
    .busy(busy));
  // Observed pin and fault vectors
  assign obs = {2'h0, currentReduced, monitorOut, pbi, pb, pai, pa};
  assign flt = {3'h0, anyFaultNOut, anyFaultNOe, faultKindLevel,
    pa | pai | pb | pbi};
  // Free-running clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Expected drives from the index, gated by on
  function automatic logic [7:0] pins(input int i, input logic on,
    input logic red);
    return {2'h0, red, i < 32, on && i > 32, on && i > 0 && i < 32,
      on && i > 16 && i < 48, on && (i < 16 || i > 48)};
  endfunction
  task automatic close_out;
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_pins(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t pins %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t read %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk); // Idle edge, so no signal is driven twice at once
  endtask
  task automatic rd(input logic [7:0] a, input logic e,
    input logic [31:0] m, input logic [31:0] v);
    notes.push_back({e, m, v & m});
    apb(a, 1'b0, 32'h00000000);
  endtask
  task automatic run_steps;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    while (busy) @(posedge mclk);
  endtask
  // Read answers against the oldest note
  always @(posedge mclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      note = notes.pop_front();
      chk_word({pslverr, prdata & note[63:32]},
        {note[64], note[31:0]});
    end
  end
  // Hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fails++;
      close_out();
    end
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, go, bothEdges, pulses} = '0;
    {rotationDirection, bit0, bit1, enable, overCurrentSense} = '0;
    {flybackSense, overheatSense, setpointReached} = '0;
    {stepEdgeSelect, systemResetN, reset, pstrb} = 7'h7F;
    seed = 32'h00013DC3;
    idx = 8;
    steps = 0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(ADDR_CTRL, 1'b0, 32'h00000001, 32'h00000001);
    rd(ADDR_STATUS, 1'b0, 32'h0000003F, idx);
    rd(ADDR_STEPS, 1'b0, 32'h0000FFFF, 32'h00000000);
    rd(8'h0C, 1'b1, 32'hFFFFFFFF, 32'h00000000);
    enable <= 1'b1;
    repeat (8) @(posedge mclk);
    chk_pins(obs, pins(idx, 1'b1, 1'b0));
    // Every edge and mode setting, random direction and burst
    for (int k = 0; k < 8; k++)
    begin
      seed = xs(seed);
      stepEdgeSelect <= !k[2];
      bit0 <= k[0];
      bit1 <= k[1];
      bothEdges <= k[2];
      rotationDirection <= seed[0];
      pulses <= 2'h1 + {1'b0, seed[1]};
      run_steps();
      n = (1 + seed[1]) * (k[2] ? 2 : 1);
      idx = (idx + 512 + (seed[0] ? -n : n) * ((k[2] ? 8 : 16) >> k[1:0])) % 64;
      steps += n;
      rd(ADDR_STATUS, 1'b0, 32'h0000003F, idx);
      rd(ADDR_STEPS, 1'b0, 32'h0000FFFF, steps);
      chk_pins(obs, pins(idx, 1'b1, k == 4 && idx[3]));
    end
    enable <= 1'b0;
    run_steps();
    chk_pins(obs, pins(idx, 1'b0, 1'b0));
    enable <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(ADDR_STATUS, 1'b0, 32'h0000003F, idx);
    apb(ADDR_CTRL, 1'b1, 32'h00000000);
    repeat (6) @(posedge mclk);
    chk_pins(obs, pins(idx, 1'b0, 1'b0));
    apb(ADDR_CTRL, 1'b1, 32'h00000001);
    // Clean pass with flyback seen, then each fault kind latched
    for (int f = 0; f < 4; f++)
    begin
      setpointReached <= (f < 2);
      flybackSense <= (f == 0);
      overCurrentSense <= (f == 2);
      overheatSense <= (f == 3);
      for (int w = 0; w < 900 && anyFaultNOe !== 1'b1; w++)
        @(posedge mclk);
      {setpointReached, overCurrentSense} <= 2'h0;
      {overheatSense, flybackSense} <= 2'h0;
      // Long enough for the chopper to come back on when no fault
      repeat (420) @(posedge mclk);
      chk_pins(flt, {4'h0, f != 0, 2'(f), f == 0});
      systemResetN <= 1'b0;
      repeat (3) @(posedge mclk);
      systemResetN <= 1'b1;
      repeat (10) @(posedge mclk);
      idx = 8;
      chk_pins(flt, 8'h01);
      rd(ADDR_STATUS, 1'b0, 32'h0000E03F, idx);
    end
    close_out();
  end
endmodule // tb_spsfl_sequencer
